// ### mgmt_master.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// MAC-side management controller model
// ------------------------------------------------------------
module mgmt_master (
    input wire logic i_clk, // Core clock used to pace the frame
    input wire logic i_mdio, // Resolved data wire, pulled up
    output logic o_mdc, // Management clock, still between frames
    output logic o_mdio_out, // Value this side drives
    output logic o_mdio_oe // High while this side drives
);
    // Half period in core clocks; the PHY asks for at least 4
    localparam int HALF = 8;

    // Idle: clock low, data released to the pull-up
    initial
    begin
        o_mdc = 1'b0;
        o_mdio_out = 1'b0;
        o_mdio_oe = 1'b0;
    end

    // Data changes while the clock is low and is taken at the rise
    task automatic bit_cycle(input logic drv, input logic val,
                             output logic smp);
        @(posedge i_clk);
        #1;
        o_mdc = 1'b0;
        o_mdio_oe = drv;
        o_mdio_out = val;
        repeat (HALF) @(posedge i_clk);
        #1;
        smp = i_mdio;
        o_mdc = 1'b1;
        repeat (HALF - 1) @(posedge i_clk);
    endtask

    // Whole frame: preamble, start, op, addresses, turnaround, word
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rdata);
        logic [63:0] bits;
        logic rd_op;
        logic smp;
        rd_op = (op == phy_ctrl_pkg::OP_READ);
        bits = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
        rdata = 16'h0000;
        for (int i = 63; i >= 0; i--)
        begin
            // On reads the wire is handed over from turnaround on
            bit_cycle(!(rd_op && i < 18), bits[i], smp);
            if (i < 16)
                rdata[i] = smp;
        end
        @(posedge i_clk);
        #1;
        o_mdc = 1'b0;
        o_mdio_oe = 1'b0;
    endtask
endmodule

// ### phy_basic_control.sv
`timescale 1ns/1ns
// How it works
// R1 - Writing one to bit 15 resets the PHY state machines at once and the bit clears itself when that reset is done.
// R2 - With loopback set, transmit data is returned on the receive path and line link is dropped.
// R3 - During loopback the speed comes from the three-bit loopback speed field, not from the speed bits.
// R4 - Forced speed uses bit 6 as upper and bit 13 as lower bit: 10 is 1000 Mb/s, 01 is 100 Mb/s, 11 reserved.
// R5 - Speed pattern 00 forces 10 Mb/s.
// R6 - Speed writes stay pending until a soft reset, a negotiation restart or a power-down exit.
// R7 - Auto-negotiation enable resets to one and a written value applies only on the same three events.
// R8 - With negotiation off and 1000 Mb/s forced, the PHY still negotiates, offering only 1000BASE-T in the duplex of bit 8.
// R9 - The host reaches every PHY register through the MAC management access register.
// R10 - The register answers at PHY address 01, register 0, whatever page is selected.
// R11 - Power-down is left only when both power-down bits are zero, and leaving it does a soft reset and a restart.
// R12 - The register is carried as 16-bit words on the serial management frame.
module phy_basic_control (
    input wire logic i_clk, // Core clock, 250 MHz
    input wire logic i_rst_b, // Synchronous reset, active low
    input wire logic i_mdc, // Management clock pin
    input wire logic i_mdio_in, // Management data pin level
    output logic o_mdio_out, // Management data driven value
    output logic o_mdio_oe, // Management data drive enable
    input wire logic i_powerdown_strap_input, // Power-down strap pin
    input wire logic i_pd_copper, // Power-down bit of page 0 reg 16
    input wire logic [2:0] i_lb_speed, // Loopback speed field
    input wire phy_ctrl_pkg::gmii_s i_tx, // Transmit data from MAC
    input wire phy_ctrl_pkg::gmii_s i_line_rx, // Receive data from line
    input wire logic i_line_link, // Line link status
    output phy_ctrl_pkg::gmii_s o_rx, // Receive data to MAC
    output logic o_link_up, // Link status to MAC
    output logic o_loopback, // Loopback active
    output logic [2:0] o_lb_speed, // Speed used in loopback
    output phy_ctrl_pkg::mode_s o_mode, // Applied speed, aneg, duplex
    output logic o_core_reset, // PHY state machine reset
    output logic o_aneg_restart, // Negotiation restart pulse
    output logic o_aneg_active, // Negotiation runs
    output logic o_adv_1000_fd, // Offer only 1000BASE-T full
    output logic o_adv_1000_hd, // Offer only 1000BASE-T half
    output logic o_ignore_adv, // Advertisement registers ignored
    output logic o_powered_down // PHY held in power-down
);

    typedef enum logic [1:0] {ST_PRE, ST_HDR, ST_TA, ST_DATA} mdio_st_e;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
    logic mdio_s1_q, mdio_s2_q;
    logic strap_s1_q, strap_s2_q, strap_s3_q;
    logic mdc_rise;

    // Pins are asynchronous, so two stages before any logic looks
    always_ff @(posedge i_clk)
    begin
        mdc_s1_q <= i_mdc;
        mdc_s2_q <= mdc_s1_q;
        mdc_s3_q <= mdc_s2_q;
        mdio_s1_q <= i_mdio_in;
        mdio_s2_q <= mdio_s1_q;
        strap_s1_q <= i_powerdown_strap_input;
        strap_s2_q <= strap_s1_q;
        strap_s3_q <= strap_s2_q;
    end

    assign mdc_rise = mdc_s2_q & ~mdc_s3_q;

    // ------------------------------------------------------------
    // Serial management frame
    // ------------------------------------------------------------
    mdio_st_e st_q, st_d;
    logic [5:0] cnt_q, cnt_d;
    logic [12:0] hdr_q, hdr_d;
    logic [15:0] sh_q, sh_d;
    logic hit_q, hit_d, rd_q, rd_d;
    logic mdio_out_q, mdio_out_d, mdio_oe_q, mdio_oe_d;
    logic wr_stb;
    logic [15:0] wr_data;
    logic [15:0] ctrl_rd;

    // Frame decode; only PHY 01 reg 0 is claimed, on any page
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        hdr_d = hdr_q;
        sh_d = sh_q;
        hit_d = hit_q;
        rd_d = rd_q;
        mdio_out_d = mdio_out_q;
        mdio_oe_d = mdio_oe_q;
        wr_stb = 1'b0;
        wr_data = {sh_q[14:0], mdio_s2_q};
        if (mdc_rise)
        begin
            case (st_q)
                ST_PRE:
                begin
                    if (mdio_s2_q)
                    begin
                        if (cnt_q != phy_ctrl_pkg::PREAMBLE_BITS)
                            cnt_d = cnt_q + 6'h01;
                    end
                    else if (cnt_q == phy_ctrl_pkg::PREAMBLE_BITS)
                    begin
                        st_d = ST_HDR;
                        cnt_d = 6'h00;
                    end
                    else
                        cnt_d = 6'h00;
                end
                ST_HDR:
                begin
                    hdr_d = {hdr_q[11:0], mdio_s2_q};
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == phy_ctrl_pkg::HDR_LAST)
                    begin
                        hit_d = hdr_d[12] & // R10
                            (hdr_d[9:5] == phy_ctrl_pkg::PHY_ADDR) &
                            (hdr_d[4:0] == phy_ctrl_pkg::REG_CTRL) &
                            ((hdr_d[11:10] == phy_ctrl_pkg::OP_READ) |
                             (hdr_d[11:10] == phy_ctrl_pkg::OP_WRITE));
                        rd_d = hdr_d[11:10] == phy_ctrl_pkg::OP_READ;
                        sh_d = ctrl_rd;
                        st_d = ST_TA;
                        cnt_d = 6'h00;
                    end
                end
                ST_TA:
                begin
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == 6'h00)
                    begin
                        // Second turnaround bit is driven low on reads
                        if (hit_q && rd_q)
                        begin
                            mdio_oe_d = 1'b1; // R12
                            mdio_out_d = 1'b0;
                        end
                    end
                    else
                    begin
                        st_d = ST_DATA;
                        cnt_d = 6'h00;
                        if (rd_q)
                        begin
                            mdio_out_d = sh_q[15]; // R12
                            sh_d = {sh_q[14:0], 1'b0};
                        end
                    end
                end
                ST_DATA:
                begin
                    cnt_d = cnt_q + 6'h01;
                    if (rd_q)
                    begin
                        mdio_out_d = sh_q[15];
                        sh_d = {sh_q[14:0], 1'b0};
                    end
                    else
                        sh_d = wr_data;
                    if (cnt_q == phy_ctrl_pkg::DATA_LAST)
                    begin
                        wr_stb = hit_q & ~rd_q; // R12
                        mdio_oe_d = 1'b0;
                        mdio_out_d = 1'b0;
                        st_d = ST_PRE;
                        cnt_d = 6'h00;
                    end
                end
                default:
                begin
                    st_d = ST_PRE;
                    cnt_d = 6'h00;
                end
            endcase
        end
    end

    // Frame state registers
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            st_q <= ST_PRE;
            cnt_q <= 6'h00;
            hdr_q <= 13'h0000;
            sh_q <= 16'h0000;
            hit_q <= 1'b0;
            rd_q <= 1'b0;
            mdio_out_q <= 1'b0;
            mdio_oe_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            hdr_q <= hdr_d;
            sh_q <= sh_d;
            hit_q <= hit_d;
            rd_q <= rd_d;
            mdio_out_q <= mdio_out_d;
            mdio_oe_q <= mdio_oe_d;
        end
    end

    // ------------------------------------------------------------
    // Control register and commit logic
    // ------------------------------------------------------------
    logic srst_q, srst_d, loop_q, loop_d, aneg_q, aneg_d;
    logic pd_q, pd_d, restart_q, restart_d, duplex_q, duplex_d;
    logic [1:0] spd_q, spd_d;
    logic [3:0] srst_cnt_q, srst_cnt_d;
    logic pd_prev_q, pd_prev_d, pd_now, pd_exit;
    logic start_srst, start_restart, srst_done, commit;
    phy_ctrl_pkg::mode_s eff_q, eff_d;

    assign ctrl_rd = {srst_q, loop_q, spd_q[0], aneg_q, pd_q, 1'b0,
                      restart_q, duplex_q, 1'b0, spd_q[1], 6'h00};
    assign pd_now = pd_q | i_pd_copper;
    assign pd_exit = pd_prev_q & ~pd_now; // R11
    assign srst_done = srst_q &
        (srst_cnt_q == phy_ctrl_pkg::SRST_CYCLES - 4'h1);

    // Speed, aneg and duplex writes only touch the pending copy; the mode in use moves on
    // commit, since a speed change mid-link would corrupt traffic
    always_comb
    begin
        loop_d = loop_q;
        spd_d = spd_q;
        aneg_d = aneg_q;
        pd_d = pd_q;
        duplex_d = duplex_q;
        if (wr_stb)
        begin
            loop_d = wr_data[phy_ctrl_pkg::BIT_LOOP];
            spd_d = {wr_data[phy_ctrl_pkg::BIT_SPD_MSB],
                     wr_data[phy_ctrl_pkg::BIT_SPD_LSB]}; // R4
            aneg_d = wr_data[phy_ctrl_pkg::BIT_ANEG];
            pd_d = wr_data[phy_ctrl_pkg::BIT_PDOWN];
            duplex_d = wr_data[phy_ctrl_pkg::BIT_DUPLEX];
        end
        // Strap edges act last so the pin has the final word
        if (strap_s2_q & ~strap_s3_q)
            pd_d = 1'b1;
        if (~strap_s2_q & strap_s3_q)
            pd_d = 1'b0;
        start_srst = (wr_stb & wr_data[phy_ctrl_pkg::BIT_RESET]) |
            pd_exit; // R1 R11
        start_restart = (wr_stb & wr_data[phy_ctrl_pkg::BIT_RESTART]) |
            pd_exit; // R11
        commit = start_srst | start_restart;
        eff_d = commit ? {spd_d, aneg_d, duplex_d} : eff_q; // R6 R7
        if (start_srst)
            loop_d = phy_ctrl_pkg::RST_LOOP;
        // A new reset request wins over the self-clear
        srst_d = start_srst | (srst_q & ~srst_done); // R1
        srst_cnt_d = (start_srst | ~srst_q) ? 4'h0 : srst_cnt_q + 4'h1;
        // Negotiation always restarts as the soft reset finishes
        restart_d = start_restart | srst_done;
        pd_prev_d = pd_now;
    end

    // Control registers; power-down takes the strap level at reset
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            srst_q <= 1'b0;
            srst_cnt_q <= 4'h0;
            loop_q <= phy_ctrl_pkg::RST_LOOP;
            spd_q <= phy_ctrl_pkg::RST_SPEED;
            aneg_q <= phy_ctrl_pkg::RST_ANEG; // R7
            pd_q <= strap_s2_q;
            restart_q <= 1'b0;
            duplex_q <= phy_ctrl_pkg::RST_DUPLEX;
            pd_prev_q <= 1'b0;
            eff_q <= {phy_ctrl_pkg::RST_SPEED, phy_ctrl_pkg::RST_ANEG,
                      phy_ctrl_pkg::RST_DUPLEX};
        end
        else
        begin
            srst_q <= srst_d;
            srst_cnt_q <= srst_cnt_d;
            loop_q <= loop_d;
            spd_q <= spd_d;
            aneg_q <= aneg_d;
            pd_q <= pd_d;
            restart_q <= restart_d;
            duplex_q <= duplex_d;
            pd_prev_q <= pd_prev_d;
            eff_q <= eff_d;
        end
    end

    // ------------------------------------------------------------
    // Data path and mode outputs
    // ------------------------------------------------------------
    logic force_1000;
    assign force_1000 = ~eff_q.aneg_en &
        (eff_q.speed == phy_ctrl_pkg::SPD_1000); // R8

    // Data and negotiation outputs are registered here; o_mode, assigned below, passes speed code 00 as 10 Mb/s
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_rx <= '0;
            o_link_up <= 1'b0;
            o_lb_speed <= 3'h0;
            o_aneg_active <= 1'b0;
            o_adv_1000_fd <= 1'b0;
            o_adv_1000_hd <= 1'b0;
            o_ignore_adv <= 1'b0;
            o_powered_down <= 1'b0;
            o_aneg_restart <= 1'b0;
        end
        else
        begin
            o_rx <= loop_q ? i_tx : i_line_rx; // R2
            o_link_up <= i_line_link & ~loop_q; // R2
            o_lb_speed <= i_lb_speed; // R3
            o_aneg_active <= eff_q.aneg_en | force_1000; // R8
            o_adv_1000_fd <= force_1000 & eff_q.duplex; // R8
            o_adv_1000_hd <= force_1000 & ~eff_q.duplex; // R8
            o_ignore_adv <= force_1000; // R8
            o_powered_down <= pd_now; // R11
            o_aneg_restart <= restart_q;
        end
    end

    assign o_mdio_out = mdio_out_q;
    assign o_mdio_oe = mdio_oe_q;
    assign o_loopback = loop_q;
    assign o_mode = eff_q; // R4 R5
    assign o_core_reset = srst_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_srst_start;
        !srst_q ##1 srst_q;
    endsequence

    a_srst_self_clear: assert property (s_srst_start |-> ##[1:12] !srst_q) // R1
        else $error("soft reset did not clear itself");
    a_srst_hold: assert property (s_srst_start |-> srst_q[*8]) // R1
        else $error("soft reset shorter than its span");
    a_loop_route: assert property (loop_q |=> o_rx == $past(i_tx)) // R2
        else $error("loopback did not return transmit data");
    a_loop_no_link: assert property (loop_q |=> !o_link_up) // R2
        else $error("link shown during loopback");
    a_lb_speed_src: assert property (loop_q |=> // R3
        o_lb_speed == $past(i_lb_speed))
        else $error("loopback speed not from its field");
    a_mode_pending: assert property (!commit |=> $stable(eff_q)) // R6
        else $error("mode changed without a commit event");
    a_aneg_reset_one: assert property (@(posedge i_clk) // R7
        disable iff (1'b0) !i_rst_b |=> aneg_q && eff_q.aneg_en)
        else $error("negotiation enable not one after reset");
    a_force_1000_adv: assert property (force_1000 |=> // R8
        o_aneg_active && o_ignore_adv &&
        (o_adv_1000_fd == $past(eff_q.duplex)))
        else $error("forced 1000 did not negotiate correctly");
    a_pd_exit_reset: assert property (pd_exit |=> // R11
        srst_q && restart_q ##1 o_aneg_restart)
        else $error("power-down exit without reset and restart");
    a_foreign_quiet: assert property (!hit_q |-> !mdio_oe_q) // R10
        else $error("drove data for a foreign address");
    a_read_turnaround: assert property (mdc_rise && st_q == ST_TA && // R12
        cnt_q == 6'h00 && hit_q && rd_q |=> mdio_oe_q && !mdio_out_q)
        else $error("turnaround not driven low on read");

endmodule

// ### phy_ctrl_pkg.sv
package phy_ctrl_pkg;

    // ------------------------------------------------------------
    // Management frame addressing
    // ------------------------------------------------------------
    localparam logic [4:0] PHY_ADDR = 5'h01;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [5:0] HDR_LAST = 6'h0c;
    localparam logic [5:0] DATA_LAST = 6'h0f;

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int BIT_RESET = 15;
    localparam int BIT_LOOP = 14;
    localparam int BIT_SPD_LSB = 13;
    localparam int BIT_ANEG = 12;
    localparam int BIT_PDOWN = 11;
    localparam int BIT_RESTART = 9;
    localparam int BIT_DUPLEX = 8;
    localparam int BIT_SPD_MSB = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_LOOP = 1'b0;
    localparam logic RST_ANEG = 1'b1;
    localparam logic RST_DUPLEX = 1'b1;
    localparam logic [1:0] RST_SPEED = 2'h2;

    // ------------------------------------------------------------
    // Speed encodings, upper bit from bit 6, lower from bit 13
    // ------------------------------------------------------------
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    localparam logic [1:0] SPD_RSVD = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int SRST_TIME_NS = 40;
    localparam logic [3:0] SRST_CYCLES =
        4'((SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef struct packed {
        logic [1:0] speed;
        logic aneg_en;
        logic duplex;
    } mode_s;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } gmii_s;

endpackage

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic mdc, m_out, m_oe, phy_out, phy_oe, mdio;
    logic strap = 1'b0;
    logic pd_cu = 1'b0;
    logic line_link = 1'b1;
    logic [2:0] lb_spd = 3'h0;
    logic [2:0] lb_out;
    phy_ctrl_pkg::gmii_s tx = '0;
    phy_ctrl_pkg::gmii_s line_rx = '0;
    phy_ctrl_pkg::gmii_s rx;
    phy_ctrl_pkg::mode_s mode;
    logic link_up, loop_on, core_rst, an_rst, an_act, adv_fd, adv_hd;
    logic ign, pdn;
    logic [15:0] rd;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    int run_len = 0;
    int last_len = 0;
    int an_cnt = 0;
    // Reference model: pending (p_) and applied (a_) fields
    int p_spd = 2, p_an = 1, p_dup = 1, p_loop = 0, p_pd = 0;
    int a_spd = 2, a_an = 1, a_dup = 1;
    int spd_tab[5] = '{0, 1, 2, 3, 2};

    always #2 clk = ~clk;

    // Released wire floats to the pull-up level
    assign mdio = phy_oe ? phy_out : (m_oe ? m_out : 1'b1);

    phy_basic_control u_phy_basic_control (
        .i_clk(clk), .i_rst_b(rst_b), .i_mdc(mdc), .i_mdio_in(mdio),
        .o_mdio_out(phy_out), .o_mdio_oe(phy_oe),
        .i_powerdown_strap_input(strap), .i_pd_copper(pd_cu),
        .i_lb_speed(lb_spd), .i_tx(tx), .i_line_rx(line_rx),
        .i_line_link(line_link), .o_rx(rx), .o_link_up(link_up),
        .o_loopback(loop_on), .o_lb_speed(lb_out), .o_mode(mode),
        .o_core_reset(core_rst), .o_aneg_restart(an_rst),
        .o_aneg_active(an_act), .o_adv_1000_fd(adv_fd),
        .o_adv_1000_hd(adv_hd), .o_ignore_adv(ign), .o_powered_down(pdn)
    );

    mgmt_master u_mgmt_master (
        .i_clk(clk), .i_mdio(mdio), .o_mdc(mdc), .o_mdio_out(m_out),
        .o_mdio_oe(m_oe)
    );

    // ------------------------------------------------------------
    // Compare, report and model tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp,
                           input string what);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t %s word %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic [8:0] got, input logic [8:0] exp,
                           input string what);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t %s pins %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [15:0] exp_word();
        logic [15:0] w;
        w = 16'h0000;
        w[14] = p_loop[0];
        w[13] = p_spd[0];
        w[12] = p_an[0];
        w[11] = p_pd[0];
        w[8] = p_dup[0];
        w[6] = p_spd[1];
        return w;
    endfunction

    task automatic commit();
        a_spd = p_spd;
        a_an = p_an;
        a_dup = p_dup;
    endtask

    // Write the control word and settle; soft reset takes 10 cycles
    task automatic wr(input logic [15:0] w);
        u_mgmt_master.frame(phy_ctrl_pkg::OP_WRITE, phy_ctrl_pkg::PHY_ADDR,
                            phy_ctrl_pkg::REG_CTRL, w, rd);
        p_spd = {w[6], w[13]};
        p_an = w[12];
        p_dup = w[8];
        p_loop = w[14];
        p_pd = w[11];
        if (w[15] | w[9])
            commit();
        if (w[15])
            p_loop = 0;
        repeat (30) @(posedge clk);
        #1;
    endtask

    // Read back the word, then compare every mode-driven output
    task automatic check_state(input string what);
        logic f1k;
        logic [8:0] e;
        u_mgmt_master.frame(phy_ctrl_pkg::OP_READ, phy_ctrl_pkg::PHY_ADDR,
                            phy_ctrl_pkg::REG_CTRL, 16'h0000, rd);
        cmp_reg(rd, exp_word(), what);
        f1k = (a_an == 0) && (a_spd == 2);
        e = {3'h0, (a_an != 0) | f1k, f1k & (a_dup != 0),
             f1k & (a_dup == 0), f1k, (p_pd != 0) | pd_cu, p_loop != 0};
        cmp_pin({3'h0, an_act, adv_fd, adv_hd, ign, pdn, loop_on}, e,
                what);
        cmp_pin({5'h0, mode}, {5'h0, 2'(a_spd), a_an[0], a_dup[0]},
                what);
        $display("done: %s", what);
    endtask

    // ------------------------------------------------------------
    // Cycle counter, reset width and restart pulse monitor
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (core_rst === 1'b1)
            run_len++;
        else if (run_len != 0)
        begin
            last_len = run_len;
            run_len = 0;
        end
        if (an_rst === 1'b1)
            an_cnt++;
        if (cycles == 60000)
        begin
            err_total++;
            $display("[ERR] %0t run did not finish", $time);
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [15:0] w;
        int n;
        void'($urandom(32'h51febd30));
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (4) @(posedge clk);
        check_state("reset values");
        // Speed and negotiation writes wait for a restart
        wr(16'h2000);
        check_state("pending");
        n = an_cnt;
        wr(16'h2200);
        cmp_pin(9'(an_cnt - n), 9'h001, "restart pulse");
        check_state("restart commit");
        // Every speed code, committed by soft reset
        for (int i = 0; i < 5; i++)
        begin
            w = 16'h8000;
            w[13] = spd_tab[i][0];
            w[6] = spd_tab[i][1];
            w[8] = (i > 3) ? 1'b1 : i[0];
            wr(w);
            cmp_pin(9'(last_len), 9'(phy_ctrl_pkg::SRST_CYCLES),
                    "soft reset");
            check_state("speed code");
        end
        // Loopback: transmit returns on receive, link dropped
        wr(exp_word() | 16'h4000);
        @(posedge clk);
        #1;
        tx = 9'($urandom);
        line_rx = 9'($urandom);
        lb_spd = 3'($urandom);
        repeat (2) @(posedge clk);
        #1;
        cmp_pin(rx, tx, "loop data");
        cmp_pin({5'h0, link_up, lb_out}, {5'h0, 1'b0, lb_spd},
                "loop link");
        check_state("loop on");
        wr(exp_word() & 16'hbfff);
        cmp_pin(rx, line_rx, "normal data");
        cmp_pin({8'h0, link_up}, 9'h001, "normal link");
        // Power-down needs both bits low before it is left
        strap = 1'b1;
        repeat (10) @(posedge clk);
        p_pd = 1;
        check_state("strap down");
        pd_cu = 1'b1;
        wr(16'h0900);
        strap = 1'b0;
        repeat (10) @(posedge clk);
        p_pd = 0;
        check_state("one bit down");
        n = an_cnt;
        pd_cu = 1'b0;
        repeat (30) @(posedge clk);
        commit();
        cmp_pin({8'h0, an_cnt > n}, 9'h001, "exit restart");
        check_state("power up");
        // Frames for another address or register are ignored
        n = an_cnt;
        u_mgmt_master.frame(phy_ctrl_pkg::OP_READ, 5'h02,
                            phy_ctrl_pkg::REG_CTRL, 16'h0000, rd);
        cmp_reg(rd, 16'hffff, "other phy read");
        u_mgmt_master.frame(phy_ctrl_pkg::OP_WRITE, 5'h02,
                            phy_ctrl_pkg::REG_CTRL, 16'h8200, rd);
        u_mgmt_master.frame(phy_ctrl_pkg::OP_WRITE, phy_ctrl_pkg::PHY_ADDR,
                            5'h01, 16'hffff, rd);
        // An opcode that is neither read nor write is refused too
        u_mgmt_master.frame(2'h3, phy_ctrl_pkg::PHY_ADDR,
                            phy_ctrl_pkg::REG_CTRL, 16'h8200, rd);
        repeat (30) @(posedge clk);
        cmp_pin(9'(an_cnt - n), 9'h000, "refused writes");
        check_state("refused");
        print_verdict();
    end
endmodule
